/* logic/receiver_mode_control_regs.sv */
// mode control register bank of a low-power receiver, axi4-lite slave
// assumes the serial host port reports each access as a one-cycle strobe
// and the receive path reports wake-up, sync and end-of-message as pulses
//
// Implementation choice: register access over AXI4-Lite.
`include "mode_ctrl_params.svh"
`default_nettype none
module receiver_mode_control_regs #(
  parameter int FIFO_WIDTH    = 8,
  parameter int FIFO_DEPTH    = 16,
  parameter int TIMEOUT_CYCLES = `SYNC_TIMEOUT_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // serial host port activity
  input  wire logic        SERIAL_STROBE,
  input  wire logic [7:0]  SERIAL_ADDR,
  input  wire logic [7:0]  SERIAL_DATA,
  // receive path events
  input  wire logic        WAKEUP_FOUND,
  input  wire logic        SYNC_FOUND,
  input  wire logic        END_OF_MESSAGE,
  input  wire logic        RX_WR_EN,
  input  wire logic [7:0]  RX_WR_DATA,
  input  wire logic        RX_RD_EN,
  // block outputs
  output logic [7:0]       RX_RD_DATA,
  output logic             CLOCK_OUTPUT_ENABLE,
  output logic             RECEIVER_RUN,
  output logic             CONFIG_B_ACTIVE,
  output logic             POLLING_ACTIVE,
  output logic             FIFO_LOCKED
);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  mode_ctrl_pkg::byte_t     addr_trace_q;
  mode_ctrl_pkg::byte_t     data_trace_q;
  mode_ctrl_pkg::byte_t     mode_ctrl_q;
  mode_ctrl_pkg::op_state_t state_q;
  mode_ctrl_pkg::op_state_t state_d;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [7:0]  w_byte_q;
  logic        w_lane0_q;
  logic        wr_fire;
  logic        fifo_init;
  logic        timeout_start;
  logic        timeout_hit;
  logic        cfg_b_q;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  wire fifo_init_en  = mode_ctrl_q[`BIT_FIFO_INIT];
  wire timeout_en    = mode_ctrl_q[`BIT_TIMEOUT_EN];
  wire lock_en       = mode_ctrl_q[`BIT_FIFO_LOCK];
  wire slave_cfg_b   = mode_ctrl_q[`BIT_SLAVE_CFG];
  wire dual_cfg      = mode_ctrl_q[`BIT_DUAL_CFG];
  wire slave_rx_en   = mode_ctrl_q[`BIT_SLAVE_RX_EN];
  wire mode_polling  = mode_ctrl_q[`BIT_MODE_SEL];

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  // address and data are taken in either order, response after both
  assign S_AXI_AWREADY = !aw_held_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held_q && !S_AXI_BVALID;
  assign wr_fire       = aw_held_q && w_held_q && !S_AXI_BVALID;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_idx_q     <= '0;
      w_byte_q     <= '0;
      w_lane0_q    <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= {2'b00, S_AXI_AWADDR[7:2]};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q  <= 1'b1;
        w_byte_q  <= S_AXI_WDATA[7:0];
        w_lane0_q <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_idx_q == `IDX_MODE_CTRL0)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode control register
  // ---------------------------------------------------------------
  // write-only mode byte
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_ctrl_q <= `MODE_CTRL0_RESET;
    end else if (wr_fire && w_lane0_q &&
                 aw_idx_q == `IDX_MODE_CTRL0) begin
      mode_ctrl_q <= w_byte_q;
    end
  end

  // ---------------------------------------------------------------
  // serial tracers
  // ---------------------------------------------------------------
  // trace address and data
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_trace_q <= `TRACE_RESET;
      data_trace_q <= `TRACE_RESET;
    end else if (SERIAL_STROBE) begin
      addr_trace_q <= SERIAL_ADDR;
      data_trace_q <= SERIAL_DATA;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= RESP_OKAY;
      // mode control is write-only and reads as zero
      unique case ({2'b00, S_AXI_ARADDR[7:2]})
        `IDX_ADDR_TRACE: S_AXI_RDATA <= {24'h000000, addr_trace_q};
        `IDX_DATA_TRACE: S_AXI_RDATA <= {24'h000000, data_trace_q};
        `IDX_MODE_CTRL0: S_AXI_RDATA <= 32'h00000000;
        `IDX_FIFO_STATUS: begin
          S_AXI_RDATA <= 32'({FIFO_LOCKED, 3'h0, 8'(fifo_level),
                              4'h0, state_q});
        end
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // operating state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mode_ctrl_pkg::ST_SLEEP: begin
        if (mode_polling) begin
          state_d = mode_ctrl_pkg::ST_POLL;
        end else if (slave_rx_en) begin
          state_d = mode_ctrl_pkg::ST_SLAVE;
        end
      end
      mode_ctrl_pkg::ST_SLAVE: begin
        if (mode_polling) begin
          state_d = mode_ctrl_pkg::ST_POLL;
        end else if (!slave_rx_en) begin
          state_d = mode_ctrl_pkg::ST_SLEEP;
        end
      end
      mode_ctrl_pkg::ST_POLL: begin
        if (!mode_polling) begin
          state_d = slave_rx_en ? mode_ctrl_pkg::ST_SLAVE
                                : mode_ctrl_pkg::ST_SLEEP;
        end else if (WAKEUP_FOUND) begin
          state_d = mode_ctrl_pkg::ST_POLL_RUN;
        end
      end
      mode_ctrl_pkg::ST_POLL_RUN: begin
        if (!mode_polling) begin
          state_d = slave_rx_en ? mode_ctrl_pkg::ST_SLAVE
                                : mode_ctrl_pkg::ST_SLEEP;
        end else if (timeout_hit && timeout_en) begin
          state_d = mode_ctrl_pkg::ST_POLL;
        end
      end
      default: state_d = mode_ctrl_pkg::ST_SLEEP;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= mode_ctrl_pkg::ST_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  assign fifo_init = fifo_init_en && (state_d != state_q) &&
                     (state_d == mode_ctrl_pkg::ST_SLAVE ||
                      state_d == mode_ctrl_pkg::ST_POLL_RUN);
  // timer starts only on the step from polling into polling run
  assign timeout_start = timeout_en &&
                         state_q == mode_ctrl_pkg::ST_POLL &&
                         state_d == mode_ctrl_pkg::ST_POLL_RUN;

  // ---------------------------------------------------------------
  // configuration select
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_b_q <= 1'b0;
    end else if (state_d == mode_ctrl_pkg::ST_SLAVE) begin
      cfg_b_q <= slave_cfg_b;
    end else if (state_d == mode_ctrl_pkg::ST_POLL_RUN &&
                 state_q == mode_ctrl_pkg::ST_POLL) begin
      cfg_b_q <= 1'b0;
    end else if (state_q == mode_ctrl_pkg::ST_POLL_RUN &&
                 dual_cfg && END_OF_MESSAGE) begin
      // after A completes, move to B
      cfg_b_q <= 1'b1;
    end else if (state_d != mode_ctrl_pkg::ST_POLL_RUN) begin
      cfg_b_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs and helpers
  // ---------------------------------------------------------------
  // clock output gate
  assign CLOCK_OUTPUT_ENABLE = mode_ctrl_q[`BIT_CLKOUT_EN];
  assign RECEIVER_RUN    = state_q == mode_ctrl_pkg::ST_SLAVE ||
                           state_q == mode_ctrl_pkg::ST_POLL_RUN;
  assign POLLING_ACTIVE  = state_q == mode_ctrl_pkg::ST_POLL ||
                           state_q == mode_ctrl_pkg::ST_POLL_RUN;
  assign CONFIG_B_ACTIVE = cfg_b_q;

  sync_timer #(
    .CYCLES (TIMEOUT_CYCLES)
  ) u_timer (
    .clk     (CLOCK),
    .arst_n  (ARST_N),
    .start   (timeout_start),
    .stop    (SYNC_FOUND),
    .expired (timeout_hit)
  );

  rx_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (CLOCK),
    .arst_n   (ARST_N),
    .init     (fifo_init),
    .lock_req (lock_en && END_OF_MESSAGE),
    .wr_en    (RX_WR_EN),
    .wr_data  (RX_WR_DATA),
    .rd_en    (RX_RD_EN),
    .rd_data  (RX_RD_DATA),
    .locked   (FIFO_LOCKED),
    .level    (fifo_level)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_clkout_reset: assert property (@(posedge CLOCK)
    $rose(ARST_N) |-> CLOCK_OUTPUT_ENABLE)
    else $error("clock output not enabled after reset");
  chk_addr_trace: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) SERIAL_STROBE |=> addr_trace_q == $past(SERIAL_ADDR))
    else $error("address trace not captured");
  chk_data_trace: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) SERIAL_STROBE |=> data_trace_q == $past(SERIAL_DATA))
    else $error("data trace not captured");
  chk_mode_write: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) wr_fire && w_lane0_q &&
    aw_idx_q == `IDX_MODE_CTRL0 |=> mode_ctrl_q == $past(w_byte_q))
    else $error("mode control write lost");
  chk_slave_run: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) !mode_polling && slave_rx_en [*2]
    |-> state_q == mode_ctrl_pkg::ST_SLAVE)
    else $error("slave run not entered");
  chk_poll_mode: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) mode_polling [*2] |-> POLLING_ACTIVE)
    else $error("polling mode not entered");
  chk_init_run: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) fifo_init |=> fifo_level == '0 && !FIFO_LOCKED ||
    $past(END_OF_MESSAGE))
    else $error("fifo not initialised");
  chk_no_lock: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) !lock_en && !FIFO_LOCKED |=> !FIFO_LOCKED)
    else $error("fifo locked while lock disabled");
  sequence run_expiry_s;
    state_q == mode_ctrl_pkg::ST_POLL_RUN && mode_polling &&
    timeout_en && timeout_hit;
  endsequence
  chk_timeout_back: assert property (@(posedge CLOCK)
    disable iff (!ARST_N) run_expiry_s |=> state_q == mode_ctrl_pkg::ST_POLL)
    else $error("time-out did not return to polling");
endmodule
`default_nettype wire

/* logic/mode_ctrl_params.svh */
// constants for the receiver mode control register bank
// assumes inclusion by bare name from logic/
`ifndef MODE_CTRL_PARAMS_SVH
`define MODE_CTRL_PARAMS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_ADDR_TRACE   8'h00
`define IDX_DATA_TRACE   8'h01
`define IDX_MODE_CTRL0   8'h02
`define IDX_FIFO_STATUS  8'h08

// ---------------------------------------------------------------
// mode control field positions and reset value
// ---------------------------------------------------------------
`define BIT_FIFO_INIT    7
`define BIT_CLKOUT_EN    6
`define BIT_TIMEOUT_EN   5
`define BIT_FIFO_LOCK    4
`define BIT_SLAVE_CFG    3
`define BIT_DUAL_CFG     2
`define BIT_SLAVE_RX_EN  1
`define BIT_MODE_SEL     0
`define MODE_CTRL0_RESET 8'h40
`define TRACE_RESET      8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define SYNC_TIMEOUT_US  100
`define SYNC_TIMEOUT_CYC ((`SYNC_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

`endif

/* logic/mode_ctrl_pkg.sv */
// types for the receiver mode control register bank
// assumes nothing of its surroundings
`default_nettype none
package mode_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_SLEEP    = 4'b0001,
    ST_SLAVE    = 4'b0010,
    ST_POLL     = 4'b0100,
    ST_POLL_RUN = 4'b1000
  } op_state_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

/* logic/rx_fifo.sv */
// receive data fifo held in flip-flops, with init and end-of-message lock
// assumes init and lock requests are single-cycle pulses
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             init,
  input  wire logic             lock_req,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  locked,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      lvl_q;
  logic             lock_q;
  logic             do_wr;
  logic             do_rd;

  // a locked fifo keeps its message: writes are dropped
  assign do_wr = wr_en && !lock_q && (lvl_q != DEPTH[AW:0]);
  assign do_rd = rd_en && (lvl_q != '0);
  assign locked = lock_q;
  assign level = lvl_q;

  always_ff @(posedge clk) begin
    if (do_wr && !init) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
      rd_data <= '0;
    end else if (init) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + AW'(1);
      end
      if (do_rd) begin
        rp_q    <= rp_q + AW'(1);
        rd_data <= mem_q[rp_q];
      end
      lvl_q <= lvl_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (lock_req) begin
      // lock request wins over a same-cycle init
      lock_q <= 1'b1;
    end else if (init) begin
      lock_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* logic/sync_timer.sv */
// down-counting sync time-out timer
// assumes start and stop are single-cycle pulses
`default_nettype none
module sync_timer #(
  parameter int CYCLES = 10000
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic stop,
  output logic      expired
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic          run_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= '0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        cnt_q <= CW'(CYCLES - 1);
        run_q <= 1'b1;
      end else if (stop) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q   <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - CW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verif/receiver_mode_control_regs_bench.sv */
// self-checking bench for the receiver mode control register bank
// assumes the design files under logic/ and logic/ on the include path
`include "mode_ctrl_params.svh"
`default_nettype none
module receiver_mode_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO_CYC = 20;
  localparam logic [1:0] OK = 2'b00;
  localparam logic [1:0] SLV = 2'b10;
  logic        CLOCK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00;
  logic        S_AXI_AWVALID = 1'b0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0;
  logic [7:0]  S_AXI_ARADDR = 8'h00;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_RREADY = 1'b0;
  logic        SERIAL_STROBE = 1'b0;
  logic [7:0]  SERIAL_ADDR = 8'h00;
  logic [7:0]  SERIAL_DATA = 8'h00;
  logic        WAKEUP_FOUND = 1'b0;
  logic        SYNC_FOUND = 1'b0;
  logic        END_OF_MESSAGE = 1'b0;
  logic        RX_WR_EN = 1'b0;
  logic [7:0]  RX_WR_DATA = 8'h00;
  logic        RX_RD_EN = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, CLOCK_OUTPUT_ENABLE, RECEIVER_RUN;
  logic        CONFIG_B_ACTIVE, POLLING_ACTIVE, FIFO_LOCKED;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [7:0]  RX_RD_DATA;
  int          fail_count = 0;
  int          checked = 0;

  receiver_mode_control_regs #(.TIMEOUT_CYCLES(TO_CYC)) dut (
    .CLOCK(CLOCK), .ARST_N(ARST_N),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .SERIAL_STROBE(SERIAL_STROBE),
    .SERIAL_ADDR(SERIAL_ADDR), .SERIAL_DATA(SERIAL_DATA),
    .WAKEUP_FOUND(WAKEUP_FOUND), .SYNC_FOUND(SYNC_FOUND),
    .END_OF_MESSAGE(END_OF_MESSAGE), .RX_WR_EN(RX_WR_EN),
    .RX_WR_DATA(RX_WR_DATA), .RX_RD_EN(RX_RD_EN),
    .RX_RD_DATA(RX_RD_DATA), .CLOCK_OUTPUT_ENABLE(CLOCK_OUTPUT_ENABLE),
    .RECEIVER_RUN(RECEIVER_RUN), .CONFIG_B_ACTIVE(CONFIG_B_ACTIVE),
    .POLLING_ACTIVE(POLLING_ACTIVE), .FIFO_LOCKED(FIFO_LOCKED)
  );

  always #5 CLOCK = ~CLOCK;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  // write data carries junk above lane 0, which must be ignored
  task automatic wr(input logic [7:0] idx, input logic [7:0] val,
                    input logic [1:0] exp_resp);
    logic aw_ok;
    logic w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    S_AXI_AWADDR  <= {idx[5:0], 2'b00};
    S_AXI_WDATA   <= {24'hA5A5A5, val};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (aw_ok && w_ok && S_AXI_BVALID === 1'b1) break;
      if (!aw_ok && S_AXI_AWREADY === 1'b1) begin
        aw_ok = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w_ok && S_AXI_WREADY === 1'b1) begin
        w_ok = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    check({30'h0, S_AXI_BRESP}, {30'h0, exp_resp});
    if (n == 50) check(32'h0, 32'h1);
    S_AXI_BREADY <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] data,
                    input logic [1:0] exp_resp);
    logic ar_ok;
    int   n;
    ar_ok = 1'b0;
    data = 32'hFFFF_FFFF;
    S_AXI_ARADDR  <= {idx[5:0], 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (ar_ok && S_AXI_RVALID === 1'b1) break;
      if (!ar_ok && S_AXI_ARREADY === 1'b1) begin
        ar_ok = 1'b1;
        S_AXI_ARVALID <= 1'b0;
      end
    end
    data = S_AXI_RDATA;
    check({30'h0, S_AXI_RRESP}, {30'h0, exp_resp});
    if (n == 50) check(32'h0, 32'h1);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input logic [1:0] exp_resp);
    logic [31:0] d;
    rd(idx, d, exp_resp);
    check(d, {24'h0, exp});
  endtask

  // status: [3:0] one-hot state, [15:8] fifo level, [19] locked
  task automatic st_chk(input logic [3:0] st, input logic [7:0] lvl,
                        input logic lk);
    logic [31:0] d;
    rd(`IDX_FIFO_STATUS, d, OK);
    check(d, {12'h0, lk, 3'b000, lvl, 4'h0, st});
  endtask

  // {clock output enable, receiver run, polling active, fifo locked}
  task automatic outs(input logic [3:0] exp);
    tick(2);
    check({28'h0, CLOCK_OUTPUT_ENABLE, RECEIVER_RUN, POLLING_ACTIVE,
           FIFO_LOCKED}, {28'h0, exp});
  endtask

  task automatic cfg_b(input logic exp);
    tick(2);
    check({31'h0, CONFIG_B_ACTIVE}, {31'h0, exp});
  endtask

  task automatic push(input logic [7:0] d);
    RX_WR_EN   <= 1'b1;
    RX_WR_DATA <= d;
    @(posedge CLOCK);
    RX_WR_EN <= 1'b0;
    @(posedge CLOCK);
  endtask

  // 0 wake-up, 1 sync, 2 end of message, 3 fifo read
  task automatic pulse(input int which);
    WAKEUP_FOUND   <= (which == 0);
    SYNC_FOUND     <= (which == 1);
    END_OF_MESSAGE <= (which == 2);
    RX_RD_EN       <= (which == 3);
    @(posedge CLOCK);
    {WAKEUP_FOUND, SYNC_FOUND, END_OF_MESSAGE, RX_RD_EN} <= 4'h0;
    tick(2);
  endtask

  task automatic serial(input logic [7:0] a, input logic [7:0] d);
    SERIAL_STROBE <= 1'b1;
    SERIAL_ADDR   <= a;
    SERIAL_DATA   <= d;
    @(posedge CLOCK);
    SERIAL_STROBE <= 1'b0;
    @(posedge CLOCK);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    tick(2);
    ARST_N <= 1'b1;
    tick(1);
    rd_chk(`IDX_ADDR_TRACE, `TRACE_RESET, OK);
    rd_chk(`IDX_DATA_TRACE, `TRACE_RESET, OK);
    rd_chk(`IDX_MODE_CTRL0, 8'h00, OK);
    outs(4'b1000);
    st_chk(4'h1, 8'h00, 1'b0);
    $display("test reset_values done");
    serial(8'h3C, 8'hC3);
    rd_chk(`IDX_ADDR_TRACE, 8'h3C, OK);
    rd_chk(`IDX_DATA_TRACE, 8'hC3, OK);
    wr(`IDX_ADDR_TRACE, 8'hFF, SLV);
    wr(`IDX_DATA_TRACE, 8'hFF, SLV);
    rd_chk(`IDX_ADDR_TRACE, 8'h3C, OK);
    rd_chk(`IDX_DATA_TRACE, 8'hC3, OK);
    rd_chk(8'h03, 8'h00, SLV);
    $display("test tracers done");
    wr(`IDX_MODE_CTRL0, 8'h00, OK);
    outs(4'b0000);
    // lane 0 strobe low: the write is answered but must not land
    S_AXI_WSTRB <= 4'hE;
    wr(`IDX_MODE_CTRL0, 8'h42, OK);
    S_AXI_WSTRB <= 4'hF;
    outs(4'b0000);
    wr(`IDX_MODE_CTRL0, 8'h42, OK);
    outs(4'b1100);
    cfg_b(1'b0);
    wr(`IDX_MODE_CTRL0, 8'h4A, OK);
    cfg_b(1'b1);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    outs(4'b1000);
    $display("test slave_sleep done");
    push(8'hA1);
    push(8'hB2);
    push(8'hC3);
    st_chk(4'h1, 8'h03, 1'b0);
    pulse(3);
    check({24'h0, RX_RD_DATA}, 32'h0000_00A1);
    wr(`IDX_MODE_CTRL0, 8'hC2, OK);
    st_chk(4'h2, 8'h00, 1'b0);
    push(8'hD4);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'h42, OK);
    st_chk(4'h2, 8'h01, 1'b0);
    $display("test fifo_init_slave done");
    wr(`IDX_MODE_CTRL0, 8'h52, OK);
    push(8'hE5);
    pulse(2);
    outs(4'b1101);
    push(8'hF6);
    st_chk(4'h2, 8'h02, 1'b1);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'hC2, OK);
    outs(4'b1100);
    st_chk(4'h2, 8'h00, 1'b0);
    wr(`IDX_MODE_CTRL0, 8'h42, OK);
    push(8'h11);
    pulse(2);
    outs(4'b1100);
    $display("test fifo_lock done");
    wr(`IDX_MODE_CTRL0, 8'h41, OK);
    outs(4'b1010);
    push(8'h17);
    wr(`IDX_MODE_CTRL0, 8'hC9, OK);
    st_chk(4'h4, 8'h02, 1'b0);
    pulse(0);
    outs(4'b1110);
    cfg_b(1'b0);
    st_chk(4'h8, 8'h00, 1'b0);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'h45, OK);
    pulse(0);
    cfg_b(1'b0);
    pulse(2);
    cfg_b(1'b1);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'h41, OK);
    pulse(0);
    pulse(2);
    cfg_b(1'b0);
    $display("test self_polling done");
    // timer length is shortened through the parameter to keep runs short
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'h61, OK);
    pulse(0);
    tick(TO_CYC + 10);
    outs(4'b1010);
    pulse(0);
    pulse(1);
    tick(TO_CYC + 10);
    outs(4'b1110);
    wr(`IDX_MODE_CTRL0, 8'h40, OK);
    wr(`IDX_MODE_CTRL0, 8'h41, OK);
    pulse(0);
    tick(TO_CYC + 10);
    outs(4'b1110);
    $display("test sync_timeout done");
    serial(8'h55, 8'hAA);
    wr(`IDX_MODE_CTRL0, 8'h02, OK);
    ARST_N <= 1'b0;
    tick(2);
    ARST_N <= 1'b1;
    tick(1);
    outs(4'b1000);
    rd_chk(`IDX_ADDR_TRACE, `TRACE_RESET, OK);
    rd_chk(`IDX_DATA_TRACE, `TRACE_RESET, OK);
    $display("test mid_reset done");
    print_verdict();
  end

  // the whole sequence takes a few hundred cycles
  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
